// ### sim/stpd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module stpd_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rvalid_q,
    input wire logic upper_page_q,
    input wire logic first_synth_loop_filter_choice_q,
    input wire logic [7:0] first_synth_phase_advance_q,
    input wire logic [7:0] second_synth_phase_advance_q,
    input wire logic [7:0] first_synth_div_a_phase_q,
    input wire logic [7:0] first_synth_div_b_phase_q,
    input wire logic [31:0] first_synth_init_freq,
    input wire logic [31:0] second_synth_init_freq,
    input wire logic [31:0] first_synth_freq_q,
    input wire logic [31:0] second_synth_freq_q,
    input wire logic first_synth_tick,
    input wire logic divider_a_pulse_q,
    input wire logic divider_b_pulse_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic pg_wr_q;
    wire pg_wr = reg_wr && reg_addr == 7'h7f;
    // upper_page_q lags the page bit, so skip the cycle right after a page write
    wire lo_ok = !upper_page_q && !pg_wr_q;
    always @(posedge clk) begin
        pg_wr_q <= pg_wr;
    end
    AST_RVALID: assert property (reg_rd |=> reg_rvalid_q)
        else $error("read not answered");
    AST_PAGE: assert property (pg_wr |=> ##1 upper_page_q == $past(reg_wdata[0], 2))
        else $error("page bit wrong");
    AST_FILT0: assert property (reg_wr && reg_addr == 7'h77 && lo_ok |=>
        ##1 first_synth_loop_filter_choice_q == $past(reg_wdata[0], 2)) else $error("filter wrong");
    AST_PH0: assert property (reg_wr && reg_addr == 7'h78 && lo_ok |=>
        ##1 first_synth_phase_advance_q == $past(reg_wdata, 2)) else $error("phase0 wrong");
    AST_PH1: assert property (reg_wr && reg_addr == 7'h79 && lo_ok |=>
        ##1 second_synth_phase_advance_q == $past(reg_wdata, 2)) else $error("phase1 wrong");
    AST_COPY: assert property (first_synth_div_a_phase_q == first_synth_phase_advance_q &&
        first_synth_div_b_phase_q == first_synth_phase_advance_q) else $error("phase copy wrong");
    AST_SAME: assert property ($past(first_synth_init_freq) == $past(second_synth_init_freq)
        |-> first_synth_freq_q == second_synth_freq_q) else $error("trim differs");
    AST_DIVA: assert property (divider_a_pulse_q |-> $past(first_synth_tick, 2))
        else $error("pulse a without tick");
    AST_DIVB: assert property (divider_b_pulse_q |-> $past(first_synth_tick, 2))
        else $error("pulse b without tick");
endmodule // stpd_checker
`default_nettype wire

// ### sim/stpd_host.sv
`timescale 1ns/1ps
`default_nettype none
module stpd_host (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q,
    input wire logic reg_rvalid_q
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    // idle bus shows the inverse so a stale address or byte never passes
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata_q;
        v = reg_rvalid_q;
    endtask
    task automatic page(input logic p);
        wr(7'h7f, {7'h00, p});
    endtask
    task automatic wdiv(input logic [6:0] a, input logic [22:0] r);
        wr(a, {1'b0, r[22:16]});
        wr(a + 7'h01, r[15:8]);
        wr(a + 7'h02, r[7:0]);
    endtask
endmodule // stpd_host
`default_nettype wire

// ### sim/stpd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stpd_top_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic first_synth_tick = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid_q, upper_page_q, v;
    logic first_synth_loop_filter_choice_q, second_synth_loop_filter_choice_q;
    logic divider_a_clk_q, divider_a_pulse_q, divider_b_clk_q, divider_b_pulse_q;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_q, d, first_synth_phase_advance_q;
    logic [7:0] second_synth_phase_advance_q, first_synth_div_a_phase_q, first_synth_div_b_phase_q;
    logic [31:0] first_synth_init_freq, second_synth_init_freq;
    logic [31:0] first_synth_freq_q, second_synth_freq_q;
    logic [6:0] ta [8] = '{7'h73, 7'h74, 7'h75, 7'h76, 7'h77, 7'h78, 7'h79, 7'h7f};
    logic [7:0] te [8] = '{8'h04, 8'h6a, 8'haa, 8'hab, 8'h00, 8'h00, 8'h00, 8'h00};
    int error_cnt = 0;
    int n_checks = 0;
    int np_a, np_b, nc_a, nc_b;
    always #12.5 clk = ~clk;
    stpd_top dut (.*);
    stpd_host host (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        host.rd(a, d, v);
        chk(v, 1'b1);
        chk(d, e);
    endtask
    function automatic logic [31:0] fexp(input logic [31:0] i, input logic [31:0] t);
        logic signed [63:0] p;
        p = $signed({32'h0, i}) * $signed({{32{t[31]}}, t});
        return i + p[63:32];
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        first_synth_init_freq = 32'h1000_0000;
        second_synth_init_freq = 32'h8000_0000;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        for (int k = 0; k < 8; k++) rchk(ta[k], te[k]);
        chk(first_synth_freq_q, fexp(first_synth_init_freq, 32'h046aaaab));
        chk(second_synth_freq_q, fexp(second_synth_init_freq, 32'h046aaaab));
        rchk(7'h10, 8'h00);
        host.wr(7'h77, 8'hfd);
        rchk(7'h77, 8'h01);
        chk(first_synth_loop_filter_choice_q, 1'b1);
        chk(second_synth_loop_filter_choice_q, 1'b0);
        host.wr(7'h77, 8'h02);
        rchk(7'h77, 8'h02);
        chk(first_synth_loop_filter_choice_q, 1'b0);
        chk(second_synth_loop_filter_choice_q, 1'b1);
        host.wr(7'h78, 8'h5a);
        host.wr(7'h79, 8'ha5);
        @(negedge clk);
        chk(first_synth_phase_advance_q, 8'h5a);
        chk(first_synth_div_a_phase_q, 8'h5a);
        chk(first_synth_div_b_phase_q, 8'h5a);
        chk(second_synth_phase_advance_q, 8'ha5);
        for (int k = 0; k < 4; k++) host.wr(ta[k], k == 3 ? 8'h00 : 8'hff);
        second_synth_init_freq = first_synth_init_freq;
        repeat (2) @(negedge clk);
        chk(first_synth_freq_q, fexp(first_synth_init_freq, 32'hffffff00));
        chk(second_synth_freq_q, fexp(second_synth_init_freq, 32'hffffff00));
        host.page(1'b1);
        rchk(7'h7f, 8'h01);
        for (int k = 0; k < 6; k++) rchk(k[6:0], (k % 3 == 2) ? 8'h02 : 8'h00);
        host.wdiv(7'h00, 23'h000003);
        rchk(7'h02, 8'h03);
        first_synth_tick = 1'b1;
        repeat (10) @(negedge clk);
        np_a = 0;
        np_b = 0;
        nc_a = 0;
        nc_b = 0;
        repeat (30) begin
            @(negedge clk);
            np_a += divider_a_pulse_q;
            np_b += divider_b_pulse_q;
            nc_a += divider_a_clk_q;
            nc_b += divider_b_clk_q;
        end
        chk(np_a, 10);
        chk(np_b, 15);
        // clock stays high while the count is at or above half the ratio
        chk(nc_a, 20);
        chk(nc_b, 15);
        host.page(1'b0);
        rchk(7'h77, 8'h02);
        // a reset in mid-run must bring every register back to its reset value
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk(divider_a_pulse_q, 1'b0);
        rchk(7'h73, 8'h04);
        rchk(7'h77, 8'h00);
        host.page(1'b1);
        rchk(7'h02, 8'h02);
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule // stpd_top_tb
bind stpd_top stpd_checker chk_i (.*);
`default_nettype wire

// ### verilog/stpd_post_div.v
`timescale 1ns/1ps
`default_nettype none
`include "stpd_regs.vh"

module stpd_post_div (
    input wire clk,
    input wire reset,
    input wire synth_tick,
    input wire [22:0] ratio,
    output reg div_clk_q,
    output reg div_pulse_q
);
    reg [22:0] cnt_q;
    reg [22:0] ratio_q;
    wire [22:0] eff_ratio;
    wire [22:0] half_ratio;
    wire [22:0] cnt_inc;

    // a ratio of zero is treated as one so the counter never hangs
    assign eff_ratio = (ratio == 23'h000000) ? 23'h000001 : ratio;
    assign half_ratio = {1'b0, eff_ratio[22:1]};
    assign cnt_inc = cnt_q + 23'h000001;

    always @(posedge clk) begin
        if (reset) begin
            cnt_q <= 23'h000000;
            ratio_q <= `STPD_DIV_RST;
            div_clk_q <= 1'b0;
            div_pulse_q <= 1'b0;
        end else begin
            div_pulse_q <= 1'b0;
            ratio_q <= eff_ratio;
            if (ratio_q != eff_ratio) begin
                // restart on a new ratio rather than run past the new end
                cnt_q <= 23'h000000;
                div_clk_q <= 1'b0;
            end else if (synth_tick) begin
                if (cnt_inc >= eff_ratio) begin
                    cnt_q <= 23'h000000;
                    div_pulse_q <= 1'b1;
                    div_clk_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_inc;
                    div_clk_q <= (cnt_inc >= half_ratio);
                end
            end
        end
    end
endmodule // stpd_post_div

`default_nettype wire

// ### verilog/stpd_regs.vh
`ifndef STPD_REGS_VH
`define STPD_REGS_VH

// full 8-bit register addresses
`define STPD_TRIM_B3_ADDR 8'h73
`define STPD_TRIM_B2_ADDR 8'h74
`define STPD_TRIM_B1_ADDR 8'h75
`define STPD_TRIM_B0_ADDR 8'h76
`define STPD_FILTER_ADDR 8'h77
`define STPD_PHASE0_ADDR 8'h78
`define STPD_PHASE1_ADDR 8'h79
`define STPD_PAGE_ADDR 8'h7f
`define STPD_DIVA_B2_ADDR 8'h80
`define STPD_DIVA_B1_ADDR 8'h81
`define STPD_DIVA_B0_ADDR 8'h82
`define STPD_DIVB_B2_ADDR 8'h83
`define STPD_DIVB_B1_ADDR 8'h84
`define STPD_DIVB_B0_ADDR 8'h85

// 7-bit serial address of the page register
`define STPD_PAGE_SADDR 7'h7f

// field positions
`define STPD_FILTER0_BIT 0
`define STPD_FILTER1_BIT 1
`define STPD_PAGE_BIT 0
`define STPD_DIV_MSB 22

// reset values
`define STPD_TRIM_RST 32'h046aaaab
`define STPD_FILTER_RST 8'h00
`define STPD_PHASE_RST 8'h00
`define STPD_PAGE_RST 8'h00
`define STPD_DIV_RST 23'h000002

// trim scale: unit step is 2^-32 of nominal
`define STPD_TRIM_SHIFT 32

`endif

// ### verilog/stpd_top.v
`timescale 1ns/1ps
`default_nettype none
`include "stpd_regs.vh"

// How it works
// - trim word is a signed 32-bit value, one step equals 2^-32 of nominal
// - a single trim word serves every synthesizer alike
// - each initial frequency is scaled by one plus trim over 2^32
// - trim word resets to 0x046aaaab for the 24.576 MHz master clock
// - filter bit 0 picks first synthesizer filter: 0 external, 1 internal
// - filter bit 1 picks second synthesizer filter; both bits reset to zero
// - first synthesizer phase advances by an 8-bit count of period/256 steps
// - first phase advance applies to all clocks derived from that synthesizer
// - second synthesizer phase advances by an 8-bit count of period/256 steps
// - page bit 0 selects lower page 0x00-0x7e or upper page 0x80-0xfe
// - divider a divides the first synthesizer by a 23-bit ratio, reset two
// - divider b divides the first synthesizer by a 23-bit ratio, reset two
module stpd_top (
    input wire clk,
    input wire reset,
    input wire reg_wr,
    input wire reg_rd,
    input wire [6:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_q,
    output reg reg_rvalid_q,
    input wire [31:0] first_synth_init_freq,
    input wire [31:0] second_synth_init_freq,
    output reg [31:0] first_synth_freq_q,
    output reg [31:0] second_synth_freq_q,
    output reg first_synth_loop_filter_choice_q,
    output reg second_synth_loop_filter_choice_q,
    output reg [7:0] first_synth_phase_advance_q,
    output reg [7:0] second_synth_phase_advance_q,
    output reg [7:0] first_synth_div_a_phase_q,
    output reg [7:0] first_synth_div_b_phase_q,
    output reg upper_page_q,
    input wire first_synth_tick,
    output reg divider_a_clk_q,
    output reg divider_a_pulse_q,
    output reg divider_b_clk_q,
    output reg divider_b_pulse_q
);
    reg [31:0] trim_q;
    reg [7:0] filter_q;
    reg [7:0] phase0_q;
    reg [7:0] phase1_q;
    reg [7:0] page_q;
    reg [22:0] divider_a_value_q;
    reg [22:0] divider_b_value_q;
    reg [7:0] rdata_d;
    reg [7:0] full_addr;
    wire div_a_clk;
    wire div_a_pulse;
    wire div_b_clk;
    wire div_b_pulse;

    // fout = finit + finit * x / 2^32, x signed, rounded toward minus infinity
    function [31:0] stpd_scale;
        input [31:0] init;
        input [31:0] trim;
        reg signed [64:0] prod;
        reg signed [64:0] shifted;
        begin
            prod = $signed({1'b0, init}) * $signed({{33{trim[31]}}, trim});
            shifted = prod >>> `STPD_TRIM_SHIFT;
            stpd_scale = init + shifted[31:0];
        end
    endfunction

    // serial address carries seven bits; the page bit supplies the eighth
    always @* begin
        if (reg_addr == `STPD_PAGE_SADDR) begin
            full_addr = `STPD_PAGE_ADDR;
        end else begin
            full_addr = {page_q[`STPD_PAGE_BIT], reg_addr};
        end
    end

    always @* begin
        rdata_d = 8'h00;
        if (full_addr == `STPD_TRIM_B3_ADDR) begin
            rdata_d = trim_q[31:24];
        end else if (full_addr == `STPD_TRIM_B2_ADDR) begin
            rdata_d = trim_q[23:16];
        end else if (full_addr == `STPD_TRIM_B1_ADDR) begin
            rdata_d = trim_q[15:8];
        end else if (full_addr == `STPD_TRIM_B0_ADDR) begin
            rdata_d = trim_q[7:0];
        end else if (full_addr == `STPD_FILTER_ADDR) begin
            rdata_d = filter_q;
        end else if (full_addr == `STPD_PHASE0_ADDR) begin
            rdata_d = phase0_q;
        end else if (full_addr == `STPD_PHASE1_ADDR) begin
            rdata_d = phase1_q;
        end else if (full_addr == `STPD_PAGE_ADDR) begin
            rdata_d = page_q;
        end else if (full_addr == `STPD_DIVA_B2_ADDR) begin
            rdata_d = {1'b0, divider_a_value_q[22:16]};
        end else if (full_addr == `STPD_DIVA_B1_ADDR) begin
            rdata_d = divider_a_value_q[15:8];
        end else if (full_addr == `STPD_DIVA_B0_ADDR) begin
            rdata_d = divider_a_value_q[7:0];
        end else if (full_addr == `STPD_DIVB_B2_ADDR) begin
            rdata_d = {1'b0, divider_b_value_q[22:16]};
        end else if (full_addr == `STPD_DIVB_B1_ADDR) begin
            rdata_d = divider_b_value_q[15:8];
        end else if (full_addr == `STPD_DIVB_B0_ADDR) begin
            rdata_d = divider_b_value_q[7:0];
        end
    end

    // register writes; reserved bits are dropped and read back as zero
    always @(posedge clk) begin
        if (reset) begin
            trim_q <= `STPD_TRIM_RST;
            filter_q <= `STPD_FILTER_RST;
            phase0_q <= `STPD_PHASE_RST;
            phase1_q <= `STPD_PHASE_RST;
            page_q <= `STPD_PAGE_RST;
            divider_a_value_q <= `STPD_DIV_RST;
            divider_b_value_q <= `STPD_DIV_RST;
        end else if (reg_wr) begin
            if (full_addr == `STPD_TRIM_B3_ADDR) begin
                trim_q[31:24] <= reg_wdata;
            end else if (full_addr == `STPD_TRIM_B2_ADDR) begin
                trim_q[23:16] <= reg_wdata;
            end else if (full_addr == `STPD_TRIM_B1_ADDR) begin
                trim_q[15:8] <= reg_wdata;
            end else if (full_addr == `STPD_TRIM_B0_ADDR) begin
                trim_q[7:0] <= reg_wdata;
            end else if (full_addr == `STPD_FILTER_ADDR) begin
                filter_q <= {6'b000000, reg_wdata[1:0]};
            end else if (full_addr == `STPD_PHASE0_ADDR) begin
                phase0_q <= reg_wdata;
            end else if (full_addr == `STPD_PHASE1_ADDR) begin
                phase1_q <= reg_wdata;
            end else if (full_addr == `STPD_PAGE_ADDR) begin
                page_q <= {7'b0000000, reg_wdata[`STPD_PAGE_BIT]};
            end else if (full_addr == `STPD_DIVA_B2_ADDR) begin
                // bit 23 is expected zero from the host and is not stored
                divider_a_value_q[22:16] <= reg_wdata[6:0];
            end else if (full_addr == `STPD_DIVA_B1_ADDR) begin
                divider_a_value_q[15:8] <= reg_wdata;
            end else if (full_addr == `STPD_DIVA_B0_ADDR) begin
                divider_a_value_q[7:0] <= reg_wdata;
            end else if (full_addr == `STPD_DIVB_B2_ADDR) begin
                divider_b_value_q[22:16] <= reg_wdata[6:0];
            end else if (full_addr == `STPD_DIVB_B1_ADDR) begin
                divider_b_value_q[15:8] <= reg_wdata;
            end else if (full_addr == `STPD_DIVB_B0_ADDR) begin
                divider_b_value_q[7:0] <= reg_wdata;
            end
        end
    end

    // read data one cycle after the strobe; unmapped addresses read zero
    always @(posedge clk) begin
        if (reset) begin
            reg_rdata_q <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd) begin
                reg_rdata_q <= rdata_d;
            end
        end
    end

    // outputs steered by the configuration
    always @(posedge clk) begin
        if (reset) begin
            first_synth_freq_q <= 32'h00000000;
            second_synth_freq_q <= 32'h00000000;
            first_synth_loop_filter_choice_q <= 1'b0;
            second_synth_loop_filter_choice_q <= 1'b0;
            first_synth_phase_advance_q <= 8'h00;
            second_synth_phase_advance_q <= 8'h00;
            first_synth_div_a_phase_q <= 8'h00;
            first_synth_div_b_phase_q <= 8'h00;
            upper_page_q <= 1'b0;
        end else begin
            // one trim word, so both synthesizers move by the same fraction
            first_synth_freq_q <= stpd_scale(first_synth_init_freq, trim_q);
            second_synth_freq_q <= stpd_scale(second_synth_init_freq, trim_q);
            first_synth_loop_filter_choice_q <= filter_q[`STPD_FILTER0_BIT];
            second_synth_loop_filter_choice_q <= filter_q[`STPD_FILTER1_BIT];
            first_synth_phase_advance_q <= phase0_q;
            second_synth_phase_advance_q <= phase1_q;
            first_synth_div_a_phase_q <= phase0_q;
            first_synth_div_b_phase_q <= phase0_q;
            upper_page_q <= page_q[`STPD_PAGE_BIT];
        end
    end

    stpd_post_div u_div_a (
        .clk(clk),
        .reset(reset),
        .synth_tick(first_synth_tick),
        .ratio(divider_a_value_q),
        .div_clk_q(div_a_clk),
        .div_pulse_q(div_a_pulse)
    );

    stpd_post_div u_div_b (
        .clk(clk),
        .reset(reset),
        .synth_tick(first_synth_tick),
        .ratio(divider_b_value_q),
        .div_clk_q(div_b_clk),
        .div_pulse_q(div_b_pulse)
    );

    // retimed so the divider outputs also leave a flip-flop here, like every other top output
    always @(posedge clk) begin
        if (reset) begin
            divider_a_clk_q <= 1'b0;
            divider_a_pulse_q <= 1'b0;
            divider_b_clk_q <= 1'b0;
            divider_b_pulse_q <= 1'b0;
        end else begin
            divider_a_clk_q <= div_a_clk;
            divider_a_pulse_q <= div_a_pulse;
            divider_b_clk_q <= div_b_clk;
            divider_b_pulse_q <= div_b_pulse;
        end
    end
endmodule // stpd_top

`default_nettype wire
